// ===== rtl/ewsf_defs.svh
// Constant definitions for the event word selector and FIFO writer
`ifndef EWSF_DEFS_SVH
`define EWSF_DEFS_SVH
`define EWSF_POS_W        8
`define EWSF_WORD_W       23
`define EWSF_TAG_W        4
`define EWSF_SUB_W        3
`define EWSF_MODE_W       3
`define EWSF_TAP_N        5
`define EWSF_TAG_STAGES   3
`define EWSF_FIFO_DEPTH   512
`define EWSF_X_OFFSET     8'h00
`define EWSF_Y_OFFSET     8'h00
`define EWSF_MODE_RESET   3'h0
`define EWSF_TAG_LSB      0
`define EWSF_X_LSB        4
`define EWSF_Y_LSB        13
`define EWSF_DBL_BIT      22
`define EWSF_MN_A_LSB     4
`define EWSF_MN_B_LSB     13
`define EWSF_ENG_CODE_A   4'h1
`define EWSF_ENG_CODE_B   4'h2
// Cycles between writes; two lets pairs and close events through
`define EWSF_WRITE_GAP    2
`endif

// ===== rtl/ewsf_pkg.sv
// Types shared by the event word selector and FIFO writer
package ewsf_pkg;
    typedef enum logic [2:0] {
        EWSF_LO_WIN,
        EWSF_LO_FULL,
        EWSF_HI_WIN,
        EWSF_HI_FULL,
        EWSF_X_MN,
        EWSF_Y_MN,
        EWSF_HEIGHT,
        EWSF_ENERGY
    } ewsf_mode_e;
    typedef logic [22:0] ewsf_word_t;
endpackage

// ===== rtl/ewsf_tag_delay.sv
// Window tag delay: stages loading on inverted X lsb
`timescale 1ns/100ps
`include "ewsf_defs.svh"
module ewsf_tag_delay #(
    parameter int STAGES = `EWSF_TAG_STAGES,
    parameter int W      = `EWSF_TAG_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         x_count_lsb_i,
    input  wire logic [W-1:0] window_tag_raw_i,
    output logic      [W-1:0] window_tag_aligned_o
);
    initial
    begin
        if (STAGES < 1 || W < 1)
            $error("ewsf_tag_delay: bad parameters");
    end
    logic [W-1:0] stage_r   [STAGES];
    logic [W-1:0] stage_nxt [STAGES];
    always_comb
    begin
        stage_nxt[0] = stage_r[0];
        if (!x_count_lsb_i)
            stage_nxt[0] = window_tag_raw_i;
        for (int i = 1; i < STAGES; i++)
        begin
            stage_nxt[i] = stage_r[i];
            if (!x_count_lsb_i)
                stage_nxt[i] = stage_r[i-1];
        end
    end
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < STAGES; i++)
        begin
            if (rst_i)
                stage_r[i] <= '0;
            else
                stage_r[i] <= stage_nxt[i];
        end
    end
    assign window_tag_aligned_o = stage_r[STAGES-1];
endmodule

// ===== rtl/ewsf_pos_offset.sv
// X and Y position offset adders
`timescale 1ns/100ps
`include "ewsf_defs.svh"
module ewsf_pos_offset #(
    parameter logic [7:0] X_OFFSET = `EWSF_X_OFFSET,
    parameter logic [7:0] Y_OFFSET = `EWSF_Y_OFFSET
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] x_pixel_count_i,
    input  wire logic [7:0] y_row_count_i,
    output logic      [7:0] x_pixel_adjusted_o,
    output logic      [7:0] y_row_adjusted_o
);
    logic [7:0] x_adj_r;
    logic [7:0] x_adj_nxt;
    always_comb
    begin
        x_adj_nxt = 8'(x_pixel_count_i + X_OFFSET);
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            x_adj_r <= 8'h00;
        else
            x_adj_r <= x_adj_nxt;
    end
    assign x_pixel_adjusted_o = x_adj_r;
    assign y_row_adjusted_o   = 8'(y_row_count_i + Y_OFFSET);
endmodule

// ===== rtl/ewsf_top.sv
// Event word selector and FIFO write control
// Functional notes
// - Only low 8 bits of X and Y counters used; wrap allowed.
// - Fixed strapped offsets added to X and Y counters.
// - Adjusted Y is plain unregistered 8 bit sum.
// - Adjusted X sum registered every clock.
// - Event word is 23 bits; parity added downstream.
// - 3 bit mode latch loaded by strobe, readable in status.
// - Window tags delayed through a further 3 stages after external 2 cycle stage.
// - Tag delay stages load on inverted X count lsb.
// - All fields for the mode valid in the same cycle.
// - Mode selects one event detect tap as write trigger.
// - Mode 0 layout: tag, 9 bit X, 9 bit Y, double flag.
// - Formatted word captured in holding latch on chosen detect.
// - Write rate at most one per two clocks into 512 deep FIFO.
// - Write suppressed and word dropped while FIFO full.
// - Writes only while integration active, changed at frame transfer end.
// - Qualified event gives one cycle active low write pulse next clock.
// - Events two cycles apart are both written.
// - Modes 4-7 write one word per event, pair member alternating on each detect.
// - Effective low mode bit follows request unless top bit set.
// - Captured low bit samples effective bit on each word latch.
// - Mode codes 0..7 as low/high res, window/full, engineering.
`timescale 1ns/100ps
`include "ewsf_defs.svh"
module ewsf_top #(
    parameter logic [7:0] X_OFFSET   = `EWSF_X_OFFSET,
    parameter logic [7:0] Y_OFFSET   = `EWSF_Y_OFFSET,
    parameter int         TAG_STAGES = `EWSF_TAG_STAGES,
    parameter int         WRITE_GAP  = `EWSF_WRITE_GAP
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  x_pixel_count_i,
    input  wire logic [7:0]  y_row_count_i,
    input  wire logic [2:0]  x_subpixel_i,
    input  wire logic [2:0]  y_subpixel_i,
    input  wire logic        double_count_i,
    input  wire logic [3:0]  window_tag_raw_i,
    input  wire logic [7:0]  event_height_i,
    input  wire logic [7:0]  event_energy_i,
    input  wire logic [15:0] x_mn_i,
    input  wire logic [15:0] y_mn_i,
    input  wire logic [15:0] y_mn_late_i,
    input  wire logic [4:0]  event_detect_taps_i,
    input  wire logic        mode_load_strobe_n_i,
    input  wire logic [2:0]  mode_data_i,
    input  wire logic        integration_request_i,
    input  wire logic        frame_transfer_sync_n_i,
    input  wire logic        fifo_full_n_i,
    output logic [22:0]      fifo_input_word_o,
    output logic             fifo_write_n_o,
    output logic [2:0]       mode_status_o,
    output logic             integration_active_o,
    output logic             write_dropped_o
);
    initial
    begin
        if (WRITE_GAP < 1 || WRITE_GAP > 256)
            $error("ewsf_top: WRITE_GAP out of range");
        if (TAG_STAGES < 1)
            $error("ewsf_top: TAG_STAGES must be at least one");
    end

    // Pin synchronisers
    logic [4:0] tap_s1_r, tap_s2_r;
    logic [2:0] md_s1_r, md_s2_r;
    logic [3:0] ctl_s1_r, ctl_s2_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tap_s1_r <= 5'h00;
            tap_s2_r <= 5'h00;
            md_s1_r  <= 3'h0;
            md_s2_r  <= 3'h0;
            ctl_s1_r <= 4'hF;
            ctl_s2_r <= 4'hF;
        end
        else
        begin
            tap_s1_r <= event_detect_taps_i;
            tap_s2_r <= tap_s1_r;
            md_s1_r  <= mode_data_i;
            md_s2_r  <= md_s1_r;
            ctl_s1_r <= {mode_load_strobe_n_i, integration_request_i, frame_transfer_sync_n_i, fifo_full_n_i};
            ctl_s2_r <= ctl_s1_r;
        end
    end
    wire logic strobe_n_s = ctl_s2_r[3];
    wire logic int_req_s  = ctl_s2_r[2];
    wire logic frame_transfer_sync_n_n_s  = ctl_s2_r[1];
    wire logic full_n_s   = ctl_s2_r[0];

    logic [7:0] x_adj;
    logic [7:0] y_adj;
    ewsf_pos_offset #(
        .X_OFFSET (X_OFFSET),
        .Y_OFFSET (Y_OFFSET)
    ) u_pos (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .x_pixel_count_i    (x_pixel_count_i),
        .y_row_count_i      (y_row_count_i),
        .x_pixel_adjusted_o (x_adj),
        .y_row_adjusted_o   (y_adj)
    );
    logic [3:0] tag_aligned;
    ewsf_tag_delay #(
        .STAGES (TAG_STAGES),
        .W      (`EWSF_TAG_W)
    ) u_tag (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .x_count_lsb_i        (x_pixel_count_i[0]),
        .window_tag_raw_i     (window_tag_raw_i),
        .window_tag_aligned_o (tag_aligned)
    );

    // Control state
    logic [2:0]  mode_r, mode_nxt;
    logic        strobe_d_r, strobe_d_nxt;
    logic        frame_transfer_sync_n_d_r, frame_transfer_sync_n_d_nxt;
    logic        integration_active_r, integration_active_nxt;
    logic        mode_low_eff_r, mode_low_eff_nxt;
    logic        mode_low_cap_r, mode_low_cap_nxt;
    logic [22:0] word_r, word_nxt;
    logic        wr_n_r, wr_n_nxt;
    logic        drop_r, drop_nxt;
    logic [7:0]  gap_r, gap_nxt;

    wire logic mode_top_bit       = mode_r[2];
    wire logic mode_mid_bit       = mode_r[1];
    wire logic mode_low_requested = mode_r[0];
    wire logic [2:0] mode_eff     = {mode_top_bit, mode_mid_bit, mode_low_eff_r};

    // Detect tap per effective mode
    function automatic logic pick_tap(input logic [2:0] m, input logic [4:0] t);
        unique case (ewsf_pkg::ewsf_mode_e'(m))
            ewsf_pkg::EWSF_LO_WIN:  pick_tap = t[2];
            ewsf_pkg::EWSF_LO_FULL: pick_tap = t[2];
            ewsf_pkg::EWSF_HI_WIN:  pick_tap = t[2];
            ewsf_pkg::EWSF_HI_FULL: pick_tap = t[2];
            ewsf_pkg::EWSF_X_MN:    pick_tap = t[0];
            ewsf_pkg::EWSF_Y_MN:    pick_tap = t[1];
            ewsf_pkg::EWSF_HEIGHT:  pick_tap = t[3];
            ewsf_pkg::EWSF_ENERGY:  pick_tap = t[4];
        endcase
    endfunction

    // Word formatter
    function automatic ewsf_pkg::ewsf_word_t fmt(input logic [2:0] m);
        ewsf_pkg::ewsf_word_t w;
        w = '0;
        w[`EWSF_DBL_BIT] = double_count_i;
        unique case (ewsf_pkg::ewsf_mode_e'(m))
            ewsf_pkg::EWSF_LO_WIN, ewsf_pkg::EWSF_LO_FULL:
            begin
                w[`EWSF_TAG_LSB +: 4] = tag_aligned;
                w[`EWSF_X_LSB +: 9]   = {x_adj[6:0], x_subpixel_i[2:1]};
                w[`EWSF_Y_LSB +: 9]   = {y_adj[6:0], y_subpixel_i[2:1]};
            end
            ewsf_pkg::EWSF_HI_WIN, ewsf_pkg::EWSF_HI_FULL:
            begin
                w[`EWSF_TAG_LSB +: 4] = tag_aligned;
                w[`EWSF_X_LSB +: 9]   = {x_adj[5:0], x_subpixel_i};
                w[`EWSF_Y_LSB +: 9]   = {y_adj[5:0], y_subpixel_i};
            end
            ewsf_pkg::EWSF_X_MN:
            begin
                w[`EWSF_TAG_LSB +: 4]  = `EWSF_ENG_CODE_A;
                w[`EWSF_MN_A_LSB +: 8] = x_mn_i[7:0];
                w[`EWSF_MN_B_LSB +: 8] = x_mn_i[15:8];
            end
            ewsf_pkg::EWSF_Y_MN:
            begin
                w[`EWSF_TAG_LSB +: 4]  = `EWSF_ENG_CODE_B;
                w[`EWSF_MN_A_LSB +: 8] = y_mn_late_i[7:0];
                w[`EWSF_MN_B_LSB +: 8] = y_mn_late_i[15:8];
            end
            ewsf_pkg::EWSF_HEIGHT:
            begin
                w[`EWSF_TAG_LSB +: 4]  = `EWSF_ENG_CODE_A;
                w[`EWSF_MN_A_LSB +: 8] = event_height_i;
            end
            ewsf_pkg::EWSF_ENERGY:
            begin
                w[`EWSF_TAG_LSB +: 4]  = `EWSF_ENG_CODE_B;
                w[`EWSF_MN_A_LSB +: 8] = event_energy_i;
            end
        endcase
        return w;
    endfunction

    // Write qualification
    logic chosen;
    logic qualified;
    always_comb
    begin
        chosen    = pick_tap(mode_eff, tap_s2_r);
        qualified = chosen && full_n_s && integration_active_r && (gap_r == 8'h00);
    end

    // Mode latch
    always_comb
    begin
        mode_nxt     = mode_r;
        strobe_d_nxt = strobe_n_s;
        if (strobe_d_r && !strobe_n_s)
            mode_nxt = md_s2_r;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_r     <= `EWSF_MODE_RESET;
            strobe_d_r <= 1'b1;
        end
        else
        begin
            mode_r     <= mode_nxt;
            strobe_d_r <= strobe_d_nxt;
        end
    end

    // Integration active latch, changed only at frame transfer end
    always_comb
    begin
        frame_transfer_sync_n_d_nxt = frame_transfer_sync_n_n_s;
        integration_active_nxt = integration_active_r;
        if (!frame_transfer_sync_n_d_r && frame_transfer_sync_n_n_s)
            integration_active_nxt = int_req_s;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            frame_transfer_sync_n_d_r <= 1'b1;
            integration_active_r <= 1'b0;
        end
        else
        begin
            frame_transfer_sync_n_d_r <= frame_transfer_sync_n_d_nxt;
            integration_active_r <= integration_active_nxt;
        end
    end

    // Pair logic
    always_comb
    begin
        mode_low_cap_nxt = mode_low_cap_r;
        if (chosen)
            mode_low_cap_nxt = mode_low_eff_r;
        mode_low_eff_nxt = mode_top_bit ? ~mode_low_cap_nxt : mode_low_requested;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_low_eff_r <= 1'b0;
            mode_low_cap_r <= 1'b0;
        end
        else
        begin
            mode_low_eff_r <= mode_low_eff_nxt;
            mode_low_cap_r <= mode_low_cap_nxt;
        end
    end

    // Holding word and write strobe
    always_comb
    begin
        // Word latched even when the write is refused
        word_nxt = word_r;
        if (chosen)
            word_nxt = fmt(mode_eff);
        wr_n_nxt = !qualified;
        drop_nxt = chosen && !qualified;
        // Gap counter spaces successive writes
        gap_nxt  = gap_r;
        if (qualified)
            gap_nxt = 8'(WRITE_GAP - 1);
        else if (gap_r != 8'h00)
            gap_nxt = gap_r - 8'h01;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            word_r <= '0;
            wr_n_r <= 1'b1;
            drop_r <= 1'b0;
            gap_r  <= 8'h00;
        end
        else
        begin
            word_r <= word_nxt;
            wr_n_r <= wr_n_nxt;
            drop_r <= drop_nxt;
            gap_r  <= gap_nxt;
        end
    end

    assign fifo_input_word_o    = word_r;
    assign fifo_write_n_o       = wr_n_r;
    assign mode_status_o        = mode_r;
    assign integration_active_o = integration_active_r;
    assign write_dropped_o      = drop_r;
endmodule

// ===== sim/ewsf_top_sva.sv
// Port-level checker for the event word selector and FIFO writer
`timescale 1ns/100ps
module ewsf_top_sva (
    input logic        clk_i,
    input logic        rst_i,
    input logic [4:0]  event_detect_taps_i,
    input logic        mode_load_strobe_n_i,
    input logic        frame_transfer_sync_n_i,
    input logic        fifo_full_n_i,
    input logic [22:0] fifo_input_word_o,
    input logic        fifo_write_n_o,
    input logic [2:0]  mode_status_o,
    input logic        integration_active_o,
    input logic        write_dropped_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_wr_one;
        !fifo_write_n_o |=> fifo_write_n_o;
    endproperty
    a_wr_one: assert property (p_wr_one) else $error("write pulse longer than one cycle");
    property p_wr_int;
        !fifo_write_n_o |-> integration_active_o;
    endproperty
    a_wr_int: assert property (p_wr_int) else $error("write outside integration");
    property p_full;
        !fifo_full_n_i [*4] |-> fifo_write_n_o;
    endproperty
    a_full: assert property (p_full) else $error("write while FIFO full");
    property p_drop;
        write_dropped_o |-> fifo_write_n_o;
    endproperty
    a_drop: assert property (p_drop) else $error("dropped and written together");
    property p_wr_cause;
        $fell(fifo_write_n_o) |-> $past(|event_detect_taps_i, 3);
    endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("write without detect tap");
    property p_word_cause;
        $changed(fifo_input_word_o) |-> $past(|event_detect_taps_i, 3);
    endproperty
    a_word_cause: assert property (p_word_cause) else $error("word changed without detect");
    property p_mode_hold;
        mode_load_strobe_n_i [*6] |=> $stable(mode_status_o);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without strobe");
    property p_int_hold;
        frame_transfer_sync_n_i [*6] |=> $stable(integration_active_o);
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("integration changed off frame end");
    c_wr: cover property (!fifo_write_n_o);
    c_drop: cover property (write_dropped_o);
    c_eng: cover property (mode_status_o[2] && !fifo_write_n_o);
endmodule
bind ewsf_top ewsf_top_sva u_ewsf_top_sva (.clk_i(clk_i), .rst_i(rst_i),
    .event_detect_taps_i(event_detect_taps_i), .mode_load_strobe_n_i(mode_load_strobe_n_i),
    .frame_transfer_sync_n_i(frame_transfer_sync_n_i), .fifo_full_n_i(fifo_full_n_i),
    .fifo_input_word_o(fifo_input_word_o), .fifo_write_n_o(fifo_write_n_o), .mode_status_o(mode_status_o),
    .integration_active_o(integration_active_o), .write_dropped_o(write_dropped_o));

// ===== sim/ewsf_fifo_model.sv
// Behavioural model of the external event FIFO
`timescale 1ns/100ps
module ewsf_fifo_model #(
    parameter int DEPTH = 512
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        fifo_write_n_i,
    input  wire logic [22:0] fifo_input_word_i,
    input  wire logic        drain_i,
    output logic             fifo_full_n_o
);
    logic [22:0] mem[$];
    initial fifo_full_n_o = 1'b1;
    always @(posedge clk_i)
    begin
        if (rst_i)
            mem.delete();
        if (!rst_i && drain_i && mem.size() > 0)
            void'(mem.pop_front());
        if (!rst_i && !fifo_write_n_i && mem.size() < DEPTH)
            mem.push_back(fifo_input_word_i);
    end
    always @(negedge clk_i)
        fifo_full_n_o <= (mem.size() < DEPTH);
endmodule

// ===== sim/ewsf_top_tb.sv
// Self-checking testbench for the event word selector and FIFO writer
`timescale 1ns/100ps
module ewsf_top_tb;
    localparam logic [7:0] XO = 8'hC5;
    localparam logic [7:0] YO = 8'h92;
    logic clk_i = 1'b0, rst_i = 1'b1, dbl = 1'b0, strobe_n = 1'b1, int_req = 1'b0, frame_transfer_sync_n_n = 1'b1;
    logic drain = 1'b0, full_n, write_n, active, dropped;
    logic [7:0] xc = 8'h00, yc = 8'h00;
    logic [2:0] xs = 3'h0, ys = 3'h0, mdata = 3'h0, mstat;
    logic [3:0] tag = 4'h0;
    logic [4:0] taps = 5'h00;
    logic [22:0] word;
    int miscompares = 0, check_count = 0, cycles = 0, wr, dr;
    always #5 clk_i = ~clk_i;
    ewsf_top #(.X_OFFSET(XO), .Y_OFFSET(YO)) u_ewsf_top (.clk_i(clk_i), .rst_i(rst_i), .x_pixel_count_i(xc),
        .y_row_count_i(yc), .x_subpixel_i(xs), .y_subpixel_i(ys), .double_count_i(dbl),
        .window_tag_raw_i(tag), .event_height_i(8'h5A), .event_energy_i(8'hA3), .x_mn_i(16'h1234),
        .y_mn_i(16'h5678), .y_mn_late_i(16'h9ABC), .event_detect_taps_i(taps), .mode_load_strobe_n_i(strobe_n),
        .mode_data_i(mdata), .integration_request_i(int_req), .frame_transfer_sync_n_i(frame_transfer_sync_n_n),
        .fifo_full_n_i(full_n), .fifo_input_word_o(word), .fifo_write_n_o(write_n), .mode_status_o(mstat),
        .integration_active_o(active), .write_dropped_o(dropped));
    ewsf_fifo_model u_ewsf_fifo_model (.clk_i(clk_i), .rst_i(rst_i), .fifo_write_n_i(write_n),
        .fifo_input_word_i(word), .drain_i(drain), .fifo_full_n_o(full_n));
    task automatic chk(input logic [22:0] got, input logic [22:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic fire(input logic [4:0] t, input int n, input int sep);
        wr = 0;
        dr = 0;
        for (int i = 0; i < n * sep + 8; i++)
        begin
            @(negedge clk_i);
            if (write_n === 1'b0) wr++;
            if (dropped === 1'b1) dr++;
            taps = (i % sep == 0 && i / sep < n) ? t : 5'h00;
        end
    endtask
    task automatic load_mode(input logic [2:0] m);
        @(negedge clk_i);
        mdata = m;
        strobe_n = 1'b0;
        repeat (3) @(negedge clk_i);
        strobe_n = 1'b1;
        repeat (7) @(negedge clk_i);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 8; m++)
        begin
            load_mode(m[2:0]);
            chk(mstat, m);
        end
        load_mode(3'h0);
    endtask
    task automatic t_integration();
        fire(5'h1F, 1, 2);
        chk(wr, 0);
        chk(dr, 1);
        int_req = 1'b1;
        repeat (2) @(negedge clk_i);
        frame_transfer_sync_n_n = 1'b0;
        repeat (4) @(negedge clk_i);
        frame_transfer_sync_n_n = 1'b1;
        repeat (8) @(negedge clk_i);
        chk(active, 1'b1);
    endtask
    task automatic t_word(input logic [2:0] m, input logic [7:0] x, y, input logic [2:0] a, b, input logic [3:0] t,
                          input logic d);
        logic [7:0] xa, ya;
        logic [22:0] exp_w;
        load_mode(m);
        xa = x + XO;
        ya = y + YO;
        xc = x;
        yc = y;
        xs = a;
        ys = b;
        tag = t;
        dbl = d;
        repeat (16) @(negedge clk_i);
        fire(5'h1F, 1, 2);
        chk(wr, 1);
        exp_w = m[1] ? {d, ya[5:0], b, xa[5:0], a, t} : {d, ya[6:0], b[2:1], xa[6:0], a[2:1], t};
        chk(u_ewsf_fifo_model.mem[$], exp_w);
    endtask
    function automatic logic [22:0] eng_word(input logic hi, input logic second);
        if (hi)
            return {dbl, 10'h000, second ? 8'hA3 : 8'h5A, second ? 4'h2 : 4'h1};
        return second ? {dbl, 1'b0, 8'h9A, 1'b0, 8'hBC, 4'h2} : {dbl, 1'b0, 8'h12, 1'b0, 8'h34, 4'h1};
    endfunction
    task automatic t_pace();
        fire(5'h1F, 2, 2);
        chk(wr, 2);
        fire(5'h1F, 2, 1);
        chk(wr, 1);
        chk(dr, 1);
    endtask
    task automatic t_pairs();
        logic [7:0] codes;
        for (int m = 4; m < 8; m++)
        begin
            load_mode(3'h0);
            load_mode(m[2:0]);
            fire(5'h1F, 2, 2);
            chk(wr, 2);
            codes = {u_ewsf_fifo_model.mem[$-1][3:0], u_ewsf_fifo_model.mem[$][3:0]};
            chk(codes === 8'h12 || codes === 8'h21, 1'b1);
            chk(u_ewsf_fifo_model.mem[$-1], eng_word(m[1], codes[7:4] == 4'h2));
            chk(u_ewsf_fifo_model.mem[$], eng_word(m[1], codes[3:0] == 4'h2));
        end
        load_mode(3'h0);
    endtask
    task automatic t_full();
        fire(5'h1F, 512 - u_ewsf_fifo_model.mem.size(), 2);
        chk(full_n, 1'b0);
        fire(5'h1F, 1, 2);
        chk(wr, 0);
        chk(dr, 1);
        drain = 1'b1;
        for (int i = 0; i < 600 && u_ewsf_fifo_model.mem.size() > 0; i++)
            @(negedge clk_i);
        drain = 1'b0;
        repeat (4) @(negedge clk_i);
        fire(5'h1F, 1, 2);
        chk(wr, 1);
    endtask
    task automatic close_out();
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles > 12000)
        begin
            miscompares++;
            close_out();
        end
    end
    initial
    begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        t_modes();
        t_integration();
        t_word(3'h0, 8'h3E, 8'h74, 3'h1, 3'h6, 4'h5, 1'b0);
        t_word(3'h1, 8'h7C, 8'hFF, 3'h4, 3'h2, 4'hF, 1'b0);
        t_word(3'h2, 8'h80, 8'h00, 3'h5, 3'h7, 4'h3, 1'b1);
        t_word(3'h3, 8'hC2, 8'hFB, 3'h7, 3'h3, 4'hA, 1'b1);
        t_pace();
        t_pairs();
        t_full();
        close_out();
    end
endmodule
